// ==== core/cmp_event_pkg.sv ====
/*
 * holds register offsets, field positions, reset values and types for the
 * comparator event control block.
 * assumes a single 100 MHz clock domain and an 8-bit register port.
 */
package cmp_event_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CONV_CTRL_B   = 8'h03;
	localparam logic [7:0] OFS_CMP_CTRL      = 8'h08;
	localparam logic [7:0] OFS_CONV_INPUT    = 8'h07;
	localparam logic [7:0] OFS_CONV_CTRL_A   = 8'h06;
	localparam logic [7:0] OFS_IRQ_STATUS    = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK      = 8'h11;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int BIT_MUX_ENABLE   = 6;
	localparam int BIT_POWER_OFF    = 7;
	localparam int BIT_BANDGAP      = 6;
	localparam int BIT_RESULT       = 5;
	localparam int BIT_EVENT_FLAG   = 4;
	localparam int BIT_IRQ_ENABLE   = 3;
	localparam int BIT_MODE_HI      = 1;
	localparam int BIT_MODE_LO      = 0;
	localparam int BIT_CONV_ENABLE  = 7;
	localparam int BIT_GLOBAL_IE    = 0;

	// ------------------------------------------------------------------
	// reset values and masks
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_CONV_CTRL_B  = 8'h00;
	localparam logic [7:0] RST_CMP_CTRL     = 8'h00;
	localparam logic [7:0] RST_CONV_INPUT   = 8'h00;
	localparam logic [7:0] RST_CONV_CTRL_A  = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK     = 8'h00;
	localparam logic [7:0] MASK_CMP_CTRL_W  = 8'hcb;
	localparam logic [7:0] MASK_CONV_B_W    = 8'h47;
	localparam int         SYNC_STAGES      = 2;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_TOGGLE  = 2'h0,
		MODE_RSVD    = 2'h1,
		MODE_FALLING = 2'h2,
		MODE_RISING  = 2'h3
	} event_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic       powerOff;
		logic       bandgapSelect;
		logic       negFromChannel;
		logic [1:0] negChannel;
	} analog_ctrl_t;

endpackage : cmp_event_pkg

// ==== core/cmp_sync.sv ====
/*
 * two-stage synchroniser for the raw comparator output.
 * assumes the input is asynchronous to clk.
 */
`timescale 1ns/10ps
module cmp_sync
	import cmp_event_pkg::*;
#(
	parameter int STAGES = SYNC_STAGES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// data
	input  wire logic din,
	output      logic dout
);

	logic [STAGES-1:0] chain_ff;

	// ------------------------------------------------------------------
	// shift chain, only the last stage is read
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			chain_ff <= '0;
		end else begin
			chain_ff <= {chain_ff[STAGES-2:0], din};
		end
	end

	assign dout = chain_ff[STAGES-1];

endmodule : cmp_sync

// ==== core/comparator_event_control.sv ====
/*
 * digital control around an analog comparator: input routing, power-down,
 * result synchronisation, event detection, flag and interrupt request.
 * assumes a synchronous register port and the processor's global enable.
 */
// Behaviour
// RL1 - result bit high when positive exceeds negative
// RL2 - raw output synchronised, one to two cycles
// RL3 - mux enabled, converter off: channel picks negative
// RL4 - otherwise negative input pin used
// RL5 - bandgap select picks reference, else pin
// RL6 - power-off bit drives comparator power-down
// RL7 - event of chosen mode sets flag
// RL8 - mode 00 toggle, 10 fall, 11 rise
// RL9 - request only when flag and both enables
// RL10 - taking the vector clears the flag
// RL11 - writing one clears flag, zero keeps
// RL12 - software disables interrupt before power change
// RL13 - edge from current versus previous sample
// RL14 - result read-only, reserved bit reads zero
`timescale 1ns/10ps
module comparator_event_control
	import cmp_event_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// register port
	input  wire reg_req_t     req,
	output      logic [7:0]   rdata,
	// processor side
	input  wire logic         globalIrqEnable,
	input  wire logic         vectorTaken,
	output      logic         cmpIrqReq,
	output      logic         irq,
	// analog side
	input  wire logic         cmpRaw,
	output      analog_ctrl_t analogCtrl
);

	logic [7:0]   rdata_ff;
	logic         cmpIrqReq_ff;
	logic         irq_ff;
	analog_ctrl_t analogCtrl_ff;
	logic         muxEnable_ff;
	logic [2:0]   triggerSrc_ff;
	logic         convEnable_ff;
	logic [1:0]   channel_ff;
	logic         powerOff_ff;
	logic         bandgap_ff;
	logic         eventFlag_ff;
	logic         irqEnable_ff;
	event_mode_t  mode_ff;
	logic         syncOut;
	logic         prevSync_ff;
	logic         evRise;
	logic         evFall;
	logic         evHit;
	logic [1:0]   status_ff;
	logic [1:0]   mask_ff;
	logic [7:0]   nxt_rdata;
	logic         nxt_negFromChannel;

	// ------------------------------------------------------------------
	// decode helper
	// ------------------------------------------------------------------
	function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
		hit = r.wr && (r.addr == ofs);
	endfunction : hit

	// ------------------------------------------------------------------
	// synchroniser and edge detect
	// ------------------------------------------------------------------
	cmp_sync #(
		.STAGES (SYNC_STAGES)
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  (cmpRaw),
		.dout (syncOut)
	); // [RL2]

	always_ff @(posedge clk) begin
		if (rst) begin
			prevSync_ff <= 1'b0;
		end else begin
			prevSync_ff <= syncOut; // [RL13]
		end
	end

	assign evRise = syncOut && !prevSync_ff; // [RL13]
	assign evFall = !syncOut && prevSync_ff; // [RL13]

	always_comb begin
		case (mode_ff) // [RL8]
			MODE_TOGGLE:  evHit = evRise || evFall;
			MODE_FALLING: evHit = evFall;
			MODE_RISING:  evHit = evRise;
			default:      evHit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			muxEnable_ff  <= RST_CONV_CTRL_B[BIT_MUX_ENABLE];
			triggerSrc_ff <= RST_CONV_CTRL_B[2:0];
		end else if (hit(req, OFS_CONV_CTRL_B)) begin
			muxEnable_ff  <= req.wdata[BIT_MUX_ENABLE];
			triggerSrc_ff <= req.wdata[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			convEnable_ff <= RST_CONV_CTRL_A[BIT_CONV_ENABLE];
		end else if (hit(req, OFS_CONV_CTRL_A)) begin
			convEnable_ff <= req.wdata[BIT_CONV_ENABLE];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			channel_ff <= RST_CONV_INPUT[1:0];
		end else if (hit(req, OFS_CONV_INPUT)) begin
			channel_ff <= req.wdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			powerOff_ff  <= RST_CMP_CTRL[BIT_POWER_OFF];
			bandgap_ff   <= RST_CMP_CTRL[BIT_BANDGAP];
			irqEnable_ff <= RST_CMP_CTRL[BIT_IRQ_ENABLE];
			mode_ff      <= event_mode_t'(RST_CMP_CTRL[1:0]);
		end else if (hit(req, OFS_CMP_CTRL)) begin
			powerOff_ff  <= req.wdata[BIT_POWER_OFF]; // [RL6]
			bandgap_ff   <= req.wdata[BIT_BANDGAP];
			irqEnable_ff <= req.wdata[BIT_IRQ_ENABLE];
			mode_ff      <= event_mode_t'(req.wdata[BIT_MODE_HI:BIT_MODE_LO]);
		end
	end

	// ------------------------------------------------------------------
	// event flag: set wins over clear
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			eventFlag_ff <= 1'b0;
		end else if (evHit) begin
			eventFlag_ff <= 1'b1; // [RL7]
		end else if (vectorTaken) begin
			eventFlag_ff <= 1'b0; // [RL10]
		end else if (hit(req, OFS_CMP_CTRL) && req.wdata[BIT_EVENT_FLAG]) begin
			eventFlag_ff <= 1'b0; // [RL11]
		end
	end

	// ------------------------------------------------------------------
	// interrupt status and mask: bit0 event, bit1 result change
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			status_ff <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0) ? evHit : (evRise || evFall)) begin
					status_ff[i] <= 1'b1;
				end else if (hit(req, OFS_IRQ_STATUS) && req.wdata[i]) begin
					status_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_ff <= RST_IRQ_MASK[1:0];
		end else if (hit(req, OFS_IRQ_MASK)) begin
			mask_ff <= req.wdata[1:0];
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign nxt_negFromChannel = muxEnable_ff && !convEnable_ff; // [RL3] [RL4]

	always_ff @(posedge clk) begin
		if (rst) begin
			analogCtrl_ff <= '0;
			cmpIrqReq_ff  <= 1'b0;
			irq_ff        <= 1'b0;
		end else begin
			analogCtrl_ff.powerOff       <= powerOff_ff; // [RL6]
			analogCtrl_ff.bandgapSelect  <= bandgap_ff; // [RL5]
			analogCtrl_ff.negFromChannel <= nxt_negFromChannel; // [RL4]
			analogCtrl_ff.negChannel     <= channel_ff; // [RL3]
			cmpIrqReq_ff <= eventFlag_ff && irqEnable_ff && globalIrqEnable; // [RL9]
			irq_ff       <= |(status_ff & mask_ff);
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		case (req.addr)
			OFS_CMP_CTRL: begin
				nxt_rdata[BIT_POWER_OFF]  = powerOff_ff;
				nxt_rdata[BIT_BANDGAP]    = bandgap_ff;
				nxt_rdata[BIT_RESULT]     = syncOut; // [RL1] [RL14]
				nxt_rdata[BIT_EVENT_FLAG] = eventFlag_ff;
				nxt_rdata[BIT_IRQ_ENABLE] = irqEnable_ff;
				nxt_rdata[1:0]            = mode_ff;
			end
			OFS_CONV_CTRL_B: nxt_rdata = {1'b0, muxEnable_ff, 3'h0, triggerSrc_ff};
			OFS_CONV_CTRL_A: nxt_rdata = {convEnable_ff, 7'h00};
			OFS_CONV_INPUT:  nxt_rdata = {6'h00, channel_ff};
			OFS_IRQ_STATUS:  nxt_rdata = {6'h00, status_ff};
			OFS_IRQ_MASK:    nxt_rdata = {6'h00, mask_ff};
			default:         nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (req.rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign rdata      = rdata_ff;
	assign cmpIrqReq  = cmpIrqReq_ff;
	assign irq        = irq_ff;
	assign analogCtrl = analogCtrl_ff;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_sync_lat;
		@(posedge clk) disable iff (rst)
		$rose(cmpRaw) ##1 cmpRaw ##1 cmpRaw |-> syncOut;
	endproperty
	a_sync_lat: assert property (p_sync_lat) else $error("sync latency"); // [RL2]

	property p_neg_route;
		@(posedge clk) disable iff (rst)
		##1 analogCtrl.negFromChannel == $past(muxEnable_ff && !convEnable_ff);
	endproperty
	a_neg_route: assert property (p_neg_route) else $error("neg route"); // [RL3]

	property p_conv_on;
		@(posedge clk) disable iff (rst)
		convEnable_ff |=> !analogCtrl.negFromChannel;
	endproperty
	a_conv_on: assert property (p_conv_on) else $error("pin not routed"); // [RL4]

	property p_bandgap;
		@(posedge clk) disable iff (rst)
		hit(req, OFS_CMP_CTRL) |=> ##1 analogCtrl.bandgapSelect == $past(req.wdata[6], 2);
	endproperty
	a_bandgap: assert property (p_bandgap) else $error("bandgap select"); // [RL5]

	property p_power;
		@(posedge clk) disable iff (rst)
		hit(req, OFS_CMP_CTRL) && req.wdata[7] |=> ##1 analogCtrl.powerOff;
	endproperty
	a_power: assert property (p_power) else $error("power off"); // [RL6]

	property p_flag_set;
		@(posedge clk) disable iff (rst)
		evHit |=> eventFlag_ff;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set"); // [RL7]

	property p_rise_mode;
		@(posedge clk) disable iff (rst)
		mode_ff == MODE_RISING && evFall && !eventFlag_ff |=> !eventFlag_ff;
	endproperty
	a_rise_mode: assert property (p_rise_mode) else $error("fall in rise mode"); // [RL8]

	property p_irq_req;
		@(posedge clk) disable iff (rst)
		##1 cmpIrqReq == $past(eventFlag_ff && irqEnable_ff && globalIrqEnable);
	endproperty
	a_irq_req: assert property (p_irq_req) else $error("irq request"); // [RL9]

	property p_vec_clr;
		@(posedge clk) disable iff (rst)
		vectorTaken && !evHit |=> !eventFlag_ff;
	endproperty
	a_vec_clr: assert property (p_vec_clr) else $error("vector clear"); // [RL10]

	property p_w0_keep;
		@(posedge clk) disable iff (rst)
		eventFlag_ff && hit(req, OFS_CMP_CTRL) && !req.wdata[4] && !vectorTaken
			|=> eventFlag_ff;
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("flag lost"); // [RL11]

	property p_edge_once;
		@(posedge clk) disable iff (rst)
		$rose(syncOut) && mode_ff == MODE_RISING |-> evHit ##1 !evRise;
	endproperty
	a_edge_once: assert property (p_edge_once) else $error("double edge"); // [RL13]

	property p_rsvd;
		@(posedge clk) disable iff (rst)
		req.rd && req.addr == OFS_CMP_CTRL |=> !rdata[2];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // [RL14]

	c_event:  cover property (@(posedge clk) disable iff (rst) evHit);
	c_irq:    cover property (@(posedge clk) disable iff (rst) $rose(cmpIrqReq));
	c_vector: cover property (@(posedge clk) disable iff (rst) vectorTaken && eventFlag_ff);

endmodule : comparator_event_control

// ==== test/analog_cmp_model.sv ====
/*
 * behavioural model of the analog comparator and its input pins.
 * assumes levels in millivolts driven by the bench, control from the block.
 */
`timescale 1ns/10ps
module analog_cmp_model
	import cmp_event_pkg::*;
#(
	parameter int BANDGAP_MV = 1100
) (
	// control from the block
	input  analog_ctrl_t ctrl,
	// pin and channel levels
	input  int           posPinMv,
	input  int           negPinMv,
	input  int           chanMv [4],
	// comparator output
	output logic         cmpRaw
);
	int posMv;
	int negMv;

	always_comb begin
		posMv = ctrl.bandgapSelect ? BANDGAP_MV : posPinMv;
		negMv = ctrl.negFromChannel ? chanMv[ctrl.negChannel] : negPinMv;
		cmpRaw = !ctrl.powerOff && (posMv > negMv);
	end
endmodule : analog_cmp_model

// ==== test/comparator_event_control_bench.sv ====
/*
 * self-checking bench for the comparator event control block.
 * assumes the analog model in analog_cmp_model and the register port contract.
 */
`timescale 1ns/10ps
module comparator_event_control_bench
	import cmp_event_pkg::*;
;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       bg;
		logic       me;
		logic       ce;
		logic [1:0] ch;
		logic       nfc;
		logic       res;
	} route_row_t;

	logic         clk;
	logic         rst;
	reg_req_t     req;
	logic [7:0]   rdata;
	logic         globalIrqEnable;
	logic         vectorTaken;
	logic         cmpIrqReq;
	logic         irq;
	logic         cmpRaw;
	analog_ctrl_t analogCtrl;
	int           posPinMv;
	int           negPinMv;
	int           chanMv [4];
	int           nFail;
	int           checksDone;
	int           cycles;
	logic [7:0]   d;
	route_row_t   rows [8] = '{7'h00, 7'h23, 7'h26, 7'h6a, 7'h6f, 7'h75, 7'h30, 7'h4d};
	logic [3:0]   riseSets = 4'h9;
	logic [3:0]   fallSets = 4'h5;

	comparator_event_control i_dut (.clk, .rst, .req, .rdata, .globalIrqEnable,
		.vectorTaken, .cmpIrqReq, .irq, .cmpRaw, .analogCtrl);

	analog_cmp_model i_cmp (.ctrl(analogCtrl), .posPinMv, .negPinMv, .chanMv, .cmpRaw);

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		#1;
		v = rdata;
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask : settle

	task automatic summarize();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	// ------------------------------------------------------------------
	// clock and timeout
	// ------------------------------------------------------------------
	initial clk = 1'b0;
	always #5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			nFail++;
			summarize();
		end
	end

	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		req = '0;
		globalIrqEnable = 1'b0;
		vectorTaken = 1'b0;
		posPinMv = 500;
		negPinMv = 800;
		chanMv = '{200, 600, 1500, 300};
		nFail = 0;
		checksDone = 0;
		cycles = 0;
		settle(4);
		rst <= 1'b0;

		// input routing and result rows
		foreach (rows[i]) begin
			wr(OFS_CONV_CTRL_B, {1'b0, rows[i].me, 6'h00});
			wr(OFS_CONV_CTRL_A, {rows[i].ce, 7'h00});
			wr(OFS_CONV_INPUT, {6'h00, rows[i].ch});
			wr(OFS_CMP_CTRL, {1'b0, rows[i].bg, 6'h00});
			settle(4);
			#1;
			check({6'h00, analogCtrl.negFromChannel, analogCtrl.bandgapSelect},
				{6'h00, rows[i].nfc, rows[i].bg});
			if (rows[i].nfc) begin
				check({6'h00, analogCtrl.negChannel}, {6'h00, rows[i].ch});
			end
			rd(OFS_CMP_CTRL, d);
			check(d & 8'h20, {2'h0, rows[i].res, 5'h00});
		end
		$display("routing rows done");

		// event modes, rise then fall
		wr(OFS_CONV_CTRL_B, 8'h00);
		wr(OFS_CMP_CTRL, 8'h00);
		settle(4);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CMP_CTRL, 8'h10 | 8'(m));
			settle(4);
			posPinMv <= 1000;
			settle(5);
			rd(OFS_CMP_CTRL, d);
			check(d & 8'h30, {2'h0, 1'b1, riseSets[m], 4'h0});
			wr(OFS_CMP_CTRL, 8'h10 | 8'(m));
			settle(3);
			rd(OFS_CMP_CTRL, d);
			check(d & 8'h10, 8'h00);
			@(posedge clk);
			posPinMv <= 500;
			settle(5);
			rd(OFS_CMP_CTRL, d);
			check(d & 8'h30, {3'h0, fallSets[m], 4'h0});
		end
		$display("event modes done");

		// interrupt request, vector clear
		wr(OFS_CMP_CTRL, 8'h1b);
		settle(2);
		posPinMv <= 1000;
		settle(6);
		#1;
		check({7'h00, cmpIrqReq}, 8'h00);
		@(posedge clk);
		globalIrqEnable <= 1'b1;
		settle(2);
		#1;
		check({7'h00, cmpIrqReq}, 8'h01);
		wr(OFS_CMP_CTRL, 8'h0b);
		settle(2);
		#1;
		check({7'h00, cmpIrqReq}, 8'h01);
		@(posedge clk);
		vectorTaken <= 1'b1;
		@(posedge clk);
		vectorTaken <= 1'b0;
		settle(2);
		#1;
		check({7'h00, cmpIrqReq}, 8'h00);
		rd(OFS_CMP_CTRL, d);
		check(d & 8'h10, 8'h00);
		$display("interrupt request done");

		// power-down and read-only bits
		wr(OFS_CMP_CTRL, 8'h03);
		wr(OFS_CMP_CTRL, 8'h83);
		settle(1);
		#1;
		check({7'h00, analogCtrl.powerOff}, 8'h01);
		rd(OFS_CMP_CTRL, d);
		check(d & 8'h80, 8'h80);
		wr(OFS_CMP_CTRL, 8'h04);
		settle(4);
		rd(OFS_CMP_CTRL, d);
		check(d & 8'ha4, 8'h20);
		rd(8'h3f, d);
		check(d, 8'h00);
		$display("power and access done");

		// status, mask and interrupt line
		rd(OFS_IRQ_STATUS, d);
		check(d & 8'h03, 8'h03);
		check({7'h00, irq}, 8'h00);
		wr(OFS_IRQ_MASK, 8'h01);
		settle(2);
		#1;
		check({7'h00, irq}, 8'h01);
		wr(OFS_IRQ_STATUS, 8'hff);
		settle(2);
		#1;
		check({7'h00, irq}, 8'h00);
		rd(OFS_IRQ_STATUS, d);
		check(d, 8'h00);
		$display("status and mask done");

		// second reset in mid-run
		@(posedge clk);
		rst <= 1'b1;
		posPinMv <= 500;
		globalIrqEnable <= 1'b0;
		settle(4);
		rst <= 1'b0;
		foreach (chanMv[i]) begin
			rd(i == 0 ? OFS_CONV_CTRL_B : i == 1 ? OFS_CONV_CTRL_A :
				i == 2 ? OFS_CONV_INPUT : OFS_IRQ_MASK, d);
			check(d, 8'h00);
		end
		rd(OFS_CMP_CTRL, d);
		check(d, RST_CMP_CTRL);
		check({3'h0, analogCtrl}, 8'h00);
		$display("reset values done");
		summarize();
	end
endmodule : comparator_event_control_bench
